// ---- include/pamc_consts.svh ----
// Purpose: Offsets, field positions, reset values and codes of the preset mode config block
// Assumes: Byte-wide register access at printed offsets
// Notes:   Definitions only
`ifndef PAMC_CONSTS_SVH
`define PAMC_CONSTS_SVH

// ==========================================================
// Register offsets
`define PAMC_OFS_SELECT_A       8'h0b
`define PAMC_OFS_SELECT_B       8'h0c
`define PAMC_OFS_EQ_INDEX       8'h0d

// ==========================================================
// Reset values
`define PAMC_RST_SELECT_A       8'h80
`define PAMC_RST_SELECT_B       8'h00
`define PAMC_RST_EQ_INDEX       8'h00

// ==========================================================
// Field positions
`define PAMC_A_PRESCALE_BIT     7
`define PAMC_A_COMP_HI          5
`define PAMC_A_COMP_LO          4
`define PAMC_A_CURVE_HI         3
`define PAMC_A_CURVE_LO         2
`define PAMC_A_EQSRC_HI         1
`define PAMC_A_EQSRC_LO         0
`define PAMC_B_XO_HI            7
`define PAMC_B_XO_LO            4
`define PAMC_B_AM_HI            3
`define PAMC_B_AM_LO            1
`define PAMC_B_AM_EN_BIT        0
`define PAMC_EQ_INDEX_HI        4
`define PAMC_A_WRITE_MASK       8'hbf
`define PAMC_EQ_INDEX_MASK      8'h1f

// ==========================================================
// Volume codes and limits, gain in half-dB steps; AM band limit; crossover base and step in Hz
`define PAMC_MASTER_MUTE_CODE   8'hff
`define PAMC_CH_UNITY_CODE      8'h60
`define PAMC_CH_FINE_LAST       8'hd8
`define PAMC_CH_LAST_CODE       8'hec
`define PAMC_FLOOR_HALF_DB      (-160)
`define PAMC_PRESCALE_HALF_DB   (-36)
`define PAMC_AM_BAND_LAST       3'b110
`define PAMC_XO_BASE_HZ         60
`define PAMC_XO_STEP_HZ         20

`endif

// ---- include/pamc_pkg.sv ----
// Purpose: Types of the preset mode config block
// Assumes: Constants live in pamc_consts.svh
// Notes:   Enum codes follow register field codes
package pamc_pkg;
    typedef enum logic [1:0] {PAMC_EQ_USER, PAMC_EQ_PRESET, PAMC_EQ_LOUD, PAMC_EQ_NA} pamc_eq_src_t;
    typedef enum logic [1:0] {PAMC_GC_USER, PAMC_GC_AC_NOCLIP, PAMC_GC_AC_LIMCLIP,
                              PAMC_GC_NIGHT} pamc_comp_t;
    typedef logic signed [9:0] pamc_gain_t;
endpackage

// ---- hw/pamc_chan_gain.sv ----
// Purpose: Decode of one channel volume code with master offset
// Assumes: Codes are static between writes
// Notes:   Gain in half-dB steps, combinational
`timescale 1ns/10ps
`include "pamc_consts.svh"
module pamc_chan_gain (
    input  wire logic [7:0]        channel_gain_code_i,
    input  wire logic [7:0]        master_offset_code_i,
    input  wire logic              channel_gain_bypass_i,
    output pamc_pkg::pamc_gain_t   gain_o,
    output logic                   mute_o
);
    import pamc_pkg::*;
    pamc_gain_t ch_gain;
    pamc_gain_t total;
    logic       ch_mute;
    always_comb begin
        ch_mute = channel_gain_code_i > `PAMC_CH_LAST_CODE;
        if (channel_gain_code_i <= `PAMC_CH_FINE_LAST) begin
            ch_gain = pamc_gain_t'(10'sd96) - pamc_gain_t'({2'b00, channel_gain_code_i});
        end else begin
            ch_gain = pamc_gain_t'(-10'sd120)
                - pamc_gain_t'({1'b0, channel_gain_code_i - `PAMC_CH_FINE_LAST, 1'b0});
        end
        if (channel_gain_bypass_i) begin
            total  = ch_gain;
            mute_o = ch_mute;
        end else begin
            total  = ch_gain - pamc_gain_t'({2'b00, master_offset_code_i});
            mute_o = ch_mute || master_offset_code_i == `PAMC_MASTER_MUTE_CODE
                || total < pamc_gain_t'(`PAMC_FLOOR_HALF_DB);
        end
        gain_o = total;
    end
endmodule

// ---- hw/pamc_preset_config.sv ----
// Operation
// - Master offset half-dB steps, FFh mutes non-bypassed channels
// - Channel code map, EDh up hard-mutes
// - EQ source select user, preset, loudness
// - Preset EQ blocks user writes to biquads 1-4
// - Preset pre-scale forced to minus 18 dB
// - Volume curve selects master gain law
// - Compression preset selects limiter mode
// - AM enable picks band over normal setting
// - Crossover select 80 to 360 Hz
// - High-pass ch1-2, low-pass ch3 at crossover
// - Third register five-bit preset EQ index
// - First register field layout and reset
// - Second register field layout, zero reset
// - Master adds to channel, below -80 mutes
// - Bypass ignores master offset per channel
// Purpose: Preset mode registers and volume/mode decode
// Assumes: Byte register port on clk_i; volume codes held elsewhere
// Notes:   Outputs are registered decodes
`timescale 1ns/10ps
`include "pamc_consts.svh"
module pamc_preset_config (
    input  wire logic                  clk_i,
    input  wire logic                  reset_n_i,
    input  wire logic                  reg_wr_i,
    input  wire logic [7:0]            reg_addr_i,
    input  wire logic [7:0]            reg_wdata_i,
    output logic      [7:0]            reg_rdata_o,
    input  wire logic [7:0]            master_offset_code_i,
    input  wire logic [23:0]           channel_gain_code_i,
    input  wire logic [2:0]            channel_gain_bypass_i,
    input  wire logic [2:0]            switching_freq_setting_i,
    input  wire logic                  fs_family_441_i,
    input  wire logic                  coef_wr_i,
    input  wire logic                  coef_prescale_i,
    input  wire logic [2:0]            coef_biquad_i,
    input  wire logic                  prescale_user_i,
    output pamc_pkg::pamc_gain_t       gain_ch1_o,
    output pamc_pkg::pamc_gain_t       gain_ch2_o,
    output pamc_pkg::pamc_gain_t       gain_ch3_o,
    output logic      [2:0]            chan_mute_o,
    output pamc_pkg::pamc_eq_src_t     eq_source_select_o,
    output logic      [4:0]            preset_eq_number_o,
    output logic                       coef_wr_accept_o,
    output logic                       prescale_fixed_o,
    output logic      [1:0]            master_gain_law_o,
    output logic      [5:0]            curve_steps_o,
    output pamc_pkg::pamc_comp_t       compression_preset_o,
    output logic      [2:0]            switching_band_o,
    output logic                       band_table_441_o,
    output logic      [3:0]            crossover_select_o,
    output logic      [8:0]            crossover_hz_o,
    output logic                       xo_user_filters_o,
    output logic      [2:0]            xo_highpass_ch_o,
    output logic      [2:0]            xo_lowpass_ch_o
);
    import pamc_pkg::*;

    // ==========================================================
    // Registers
    logic [7:0] preset_mode_select_a;
    logic [7:0] preset_mode_select_b;
    logic [7:0] preset_eq_index;
    logic       wr_a;
    logic       wr_b;
    logic       wr_c;
    assign wr_a = reg_wr_i && reg_addr_i == `PAMC_OFS_SELECT_A;
    assign wr_b = reg_wr_i && reg_addr_i == `PAMC_OFS_SELECT_B;
    assign wr_c = reg_wr_i && reg_addr_i == `PAMC_OFS_EQ_INDEX;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            preset_mode_select_a <= `PAMC_RST_SELECT_A;
            preset_mode_select_b <= `PAMC_RST_SELECT_B;
            preset_eq_index      <= `PAMC_RST_EQ_INDEX;
        end else begin
            if (wr_a) begin
                preset_mode_select_a <= reg_wdata_i & `PAMC_A_WRITE_MASK;
            end
            if (wr_b) begin
                preset_mode_select_b <= reg_wdata_i;
            end
            if (wr_c) begin
                preset_eq_index <= reg_wdata_i & `PAMC_EQ_INDEX_MASK;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            unique case (reg_addr_i)
                `PAMC_OFS_SELECT_A: reg_rdata_o <= preset_mode_select_a;
                `PAMC_OFS_SELECT_B: reg_rdata_o <= preset_mode_select_b;
                `PAMC_OFS_EQ_INDEX: reg_rdata_o <= preset_eq_index;
                default:            reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Field decode
    pamc_eq_src_t eq_src;
    logic [2:0]   am_band;
    logic [3:0]   xo;
    logic [2:0]   next_band;
    assign eq_src  = pamc_eq_src_t'(preset_mode_select_a[`PAMC_A_EQSRC_HI:`PAMC_A_EQSRC_LO]);
    assign am_band = preset_mode_select_b[`PAMC_B_AM_HI:`PAMC_B_AM_LO];
    assign xo      = preset_mode_select_b[`PAMC_B_XO_HI:`PAMC_B_XO_LO];

    always_comb begin
        if (!preset_mode_select_b[`PAMC_B_AM_EN_BIT]) begin
            next_band = switching_freq_setting_i;
        end else if (am_band > `PAMC_AM_BAND_LAST) begin
            next_band = `PAMC_AM_BAND_LAST;
        end else begin
            next_band = am_band;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            eq_source_select_o   <= PAMC_EQ_USER;
            preset_eq_number_o   <= 5'h00;
            prescale_fixed_o     <= 1'b0;
            coef_wr_accept_o     <= 1'b0;
            master_gain_law_o    <= 2'h0;
            curve_steps_o        <= 6'h00;
            compression_preset_o <= PAMC_GC_USER;
        end else begin
            eq_source_select_o <= eq_src;
            preset_eq_number_o <= preset_eq_index[`PAMC_EQ_INDEX_HI:0];
            prescale_fixed_o   <= eq_src != PAMC_EQ_USER
                && preset_mode_select_a[`PAMC_A_PRESCALE_BIT];
            coef_wr_accept_o   <= coef_wr_i && (eq_src == PAMC_EQ_USER
                || (coef_prescale_i ? prescale_user_i
                    : (coef_biquad_i == 3'h0 || coef_biquad_i > 3'h4)));
            master_gain_law_o  <= preset_mode_select_a[`PAMC_A_CURVE_HI:`PAMC_A_CURVE_LO];
            unique case (preset_mode_select_a[`PAMC_A_CURVE_HI:`PAMC_A_CURVE_LO])
                2'h0: curve_steps_o <= 6'h00;
                2'h1: curve_steps_o <= 6'h1e;
                2'h2: curve_steps_o <= 6'h28;
                2'h3: curve_steps_o <= 6'h32;
            endcase
            compression_preset_o <=
                pamc_comp_t'(preset_mode_select_a[`PAMC_A_COMP_HI:`PAMC_A_COMP_LO]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            switching_band_o   <= 3'h0;
            band_table_441_o   <= 1'b0;
            crossover_select_o <= 4'h0;
            crossover_hz_o     <= 9'h000;
            xo_user_filters_o  <= 1'b1;
            xo_highpass_ch_o   <= 3'h0;
            xo_lowpass_ch_o    <= 3'h0;
        end else begin
            switching_band_o   <= next_band;
            band_table_441_o   <= fs_family_441_i;
            crossover_select_o <= xo;
            crossover_hz_o     <= (xo == 4'h0) ? 9'h000
                : 9'(`PAMC_XO_BASE_HZ + `PAMC_XO_STEP_HZ * xo);
            xo_user_filters_o  <= xo == 4'h0;
            xo_highpass_ch_o   <= (xo != 4'h0) ? 3'b011 : 3'b000;
            xo_lowpass_ch_o    <= (xo != 4'h0) ? 3'b100 : 3'b000;
        end
    end

    // ==========================================================
    // Channel gain
    pamc_gain_t ch_gain [3];
    logic [2:0] ch_mute;
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_ch
            pamc_chan_gain u_gain (
                .channel_gain_code_i   (channel_gain_code_i[8*g +: 8]),
                .master_offset_code_i  (master_offset_code_i),
                .channel_gain_bypass_i (channel_gain_bypass_i[g]),
                .gain_o                (ch_gain[g]),
                .mute_o                (ch_mute[g])
            );
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            gain_ch1_o  <= '0;
            gain_ch2_o  <= '0;
            gain_ch3_o  <= '0;
            chan_mute_o <= 3'h7;
        end else begin
            gain_ch1_o  <= ch_gain[0];
            gain_ch2_o  <= ch_gain[1];
            gain_ch3_o  <= ch_gain[2];
            chan_mute_o <= ch_mute;
        end
    end

    // ==========================================================
    // Checks
    property p_master_mute;
        @(posedge clk_i) disable iff (!reset_n_i)
        master_offset_code_i == 8'hff
            |=> (chan_mute_o | $past(channel_gain_bypass_i)) == 3'h7;
    endproperty
    a_master_mute: assert property (p_master_mute) else $error("master mute missed");
    property p_ch_mute;
        @(posedge clk_i) disable iff (!reset_n_i)
        channel_gain_code_i[7:0] > 8'hec |=> chan_mute_o[0];
    endproperty
    a_ch_mute: assert property (p_ch_mute) else $error("channel mute missed");
    property p_unity;
        @(posedge clk_i) disable iff (!reset_n_i)
        (channel_gain_code_i[23:16] == 8'h60 && channel_gain_bypass_i[2])
            |=> gain_ch3_o == 10'sd0;
    endproperty
    a_unity: assert property (p_unity) else $error("unity gain wrong");
    property p_prescale;
        @(posedge clk_i) disable iff (!reset_n_i)
        (eq_src != PAMC_EQ_USER && preset_mode_select_a[7]) |=> prescale_fixed_o;
    endproperty
    a_prescale: assert property (p_prescale) else $error("prescale not fixed");
    property p_coef_block;
        @(posedge clk_i) disable iff (!reset_n_i)
        (eq_src != PAMC_EQ_USER && !coef_prescale_i && coef_biquad_i == 3'h2)
            |=> !coef_wr_accept_o;
    endproperty
    a_coef_block: assert property (p_coef_block) else $error("coef write passed");
    property p_am_fallback;
        @(posedge clk_i) disable iff (!reset_n_i)
        (preset_mode_select_b == 8'h0f) |=> switching_band_o == 3'b110;
    endproperty
    a_am_fallback: assert property (p_am_fallback) else $error("band fallback wrong");
    property p_xo_hz;
        @(posedge clk_i) disable iff (!reset_n_i)
        xo == 4'hf |=> crossover_hz_o == 9'd360 && xo_lowpass_ch_o == 3'b100;
    endproperty
    a_xo_hz: assert property (p_xo_hz) else $error("crossover wrong");
    property p_reset_a;
        @(posedge clk_i) !reset_n_i |=> preset_mode_select_a == 8'h80;
    endproperty
    a_reset_a: assert property (p_reset_a) else $error("reset value wrong");
    property p_pwm_follow;
        @(posedge clk_i) disable iff (!reset_n_i)
        !preset_mode_select_b[0] |=> switching_band_o == $past(switching_freq_setting_i);
    endproperty
    a_pwm_follow: assert property (p_pwm_follow) else $error("pwm setting ignored");
endmodule

// ---- test/test_pamc_preset_config.sv ----
// Purpose: Self-checking bench for the preset mode config block
// Assumes: Byte register port, decodes one edge after a write edge
// Notes:   Gains compared in half-dB units; muted gains not compared
`timescale 1ns/10ps
`include "pamc_consts.svh"
module test_pamc_preset_config;
    import pamc_pkg::*;
    logic         clk_i, reset_n_i, reg_wr_i, fs_family_441_i, coef_wr_i;
    logic         coef_prescale_i, prescale_user_i;
    logic [7:0]   reg_addr_i, reg_wdata_i, reg_rdata_o, master_offset_code_i;
    logic [23:0]  channel_gain_code_i;
    logic [2:0]   channel_gain_bypass_i, switching_freq_setting_i, coef_biquad_i;
    pamc_gain_t   gain_ch1_o, gain_ch2_o, gain_ch3_o;
    logic [2:0]   chan_mute_o, switching_band_o, xo_highpass_ch_o, xo_lowpass_ch_o;
    pamc_eq_src_t eq_source_select_o;
    pamc_comp_t   compression_preset_o;
    logic [4:0]   preset_eq_number_o;
    logic [1:0]   master_gain_law_o;
    logic [5:0]   curve_steps_o;
    logic [3:0]   crossover_select_o;
    logic [8:0]   crossover_hz_o;
    logic         coef_wr_accept_o, prescale_fixed_o, band_table_441_o, xo_user_filters_o;
    int           errors, comparisons;

    pamc_preset_config pamc_preset_config_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .master_offset_code_i(master_offset_code_i),
        .channel_gain_code_i(channel_gain_code_i), .channel_gain_bypass_i(channel_gain_bypass_i),
        .switching_freq_setting_i(switching_freq_setting_i), .fs_family_441_i(fs_family_441_i),
        .coef_wr_i(coef_wr_i), .coef_prescale_i(coef_prescale_i), .coef_biquad_i(coef_biquad_i),
        .prescale_user_i(prescale_user_i), .gain_ch1_o(gain_ch1_o), .gain_ch2_o(gain_ch2_o),
        .gain_ch3_o(gain_ch3_o), .chan_mute_o(chan_mute_o),
        .eq_source_select_o(eq_source_select_o), .preset_eq_number_o(preset_eq_number_o),
        .coef_wr_accept_o(coef_wr_accept_o), .prescale_fixed_o(prescale_fixed_o),
        .master_gain_law_o(master_gain_law_o), .curve_steps_o(curve_steps_o),
        .compression_preset_o(compression_preset_o), .switching_band_o(switching_band_o),
        .band_table_441_o(band_table_441_o), .crossover_select_o(crossover_select_o),
        .crossover_hz_o(crossover_hz_o), .xo_user_filters_o(xo_user_filters_o),
        .xo_highpass_ch_o(xo_highpass_ch_o), .xo_lowpass_ch_o(xo_lowpass_ch_o));

    // ==========================================================
    // Clock and watchdog
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        #200us;
        errors++;
        report_and_stop();
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("errors %0d, comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        reg_addr_i <= a;
        repeat (2) @(posedge clk_i);
        #1;
        check(name, {8'h00, reg_rdata_o}, {8'h00, exp});
    endtask

    task automatic coef(input logic ps, input logic [2:0] bq, input logic usr, input logic exp);
        logic seen;
        @(posedge clk_i);
        coef_wr_i <= 1'b1;
        coef_prescale_i <= ps;
        coef_biquad_i <= bq;
        prescale_user_i <= usr;
        @(posedge clk_i);
        coef_wr_i <= 1'b0;
        #1;
        seen = coef_wr_accept_o;
        @(posedge clk_i);
        #1;
        seen = seen | coef_wr_accept_o;
        check("coef_accept", {15'h0, seen}, {15'h0, exp});
    endtask

    // Channel code in half-dB; bypass on channel 3 only
    task automatic vol_case(input logic [7:0] c, input logic [7:0] m);
        int ch, mv;
        logic cm, m1, m3;
        @(posedge clk_i);
        channel_gain_code_i <= {c, c, c};
        master_offset_code_i <= m;
        channel_gain_bypass_i <= 3'b100;
        repeat (2) @(posedge clk_i);
        #1;
        ch = (c <= 8'hd8) ? 96 - int'(c) : -120 - 2 * (int'(c) - 216);
        mv = int'(m);
        cm = c > `PAMC_CH_LAST_CODE;
        m1 = cm || (m == `PAMC_MASTER_MUTE_CODE) || (ch - mv < -160);
        m3 = cm;
        check("mute", {13'h0, chan_mute_o}, {13'h0, m3, m1, m1});
        if (!m1) check("gain1", gain_ch1_o, pamc_gain_t'(ch - mv));
        if (!m1) check("gain2", gain_ch2_o, pamc_gain_t'(ch - mv));
        if (!m3) check("gain3", gain_ch3_o, pamc_gain_t'(ch));
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        rd_chk("sel_a_rst", `PAMC_OFS_SELECT_A, 8'h80);
        rd_chk("sel_b_rst", `PAMC_OFS_SELECT_B, 8'h00);
        rd_chk("eq_idx_rst", `PAMC_OFS_EQ_INDEX, 8'h00);
        wr(`PAMC_OFS_SELECT_A, 8'hff);
        rd_chk("sel_a", `PAMC_OFS_SELECT_A, 8'hbf);
        check("prescale_fixed", {15'h0, prescale_fixed_o}, 16'h1);
        wr(`PAMC_OFS_EQ_INDEX, 8'hff);
        rd_chk("eq_idx", `PAMC_OFS_EQ_INDEX, 8'h1f);
        check("eq_number", {11'h0, preset_eq_number_o}, 16'h1f);
        wr(`PAMC_OFS_SELECT_B, 8'hff);
        rd_chk("sel_b", `PAMC_OFS_SELECT_B, 8'hff);
        wr(8'h0e, 8'h55);
        rd_chk("unmapped", 8'h0e, 8'h00);
        rd_chk("sel_a_keep", `PAMC_OFS_SELECT_A, 8'hbf);
    endtask

    task automatic t_modes();
        for (int i = 0; i < 4; i++) begin
            wr(`PAMC_OFS_SELECT_A, {i[1], 1'b0, i[1:0], i[1:0], i[1:0]});
            check("eq_src", {14'h0, eq_source_select_o}, 16'(i));
            check("law", {14'h0, master_gain_law_o}, 16'(i));
            check("steps", {10'h0, curve_steps_o}, 16'((i == 0) ? 0 : 20 + 10 * i));
            check("comp", {14'h0, compression_preset_o}, 16'(i));
            check("ps_fixed", {15'h0, prescale_fixed_o}, 16'(i >= 2));
        end
        for (int x = 0; x < 16; x++) begin
            wr(`PAMC_OFS_SELECT_B, {x[3:0], 4'h0});
            check("xo_sel", {12'h0, crossover_select_o}, 16'(x));
            check("xo_hz", {7'h0, crossover_hz_o}, 16'((x == 0) ? 0 : 60 + 20 * x));
            check("xo_user", {15'h0, xo_user_filters_o}, 16'(x == 0));
            check("xo_hp", {13'h0, xo_highpass_ch_o}, (x != 0) ? 16'h3 : 16'h0);
            check("xo_lp", {13'h0, xo_lowpass_ch_o}, (x != 0) ? 16'h4 : 16'h0);
        end
    endtask

    task automatic t_am();
        for (int k = 0; k < 16; k++) begin
            @(posedge clk_i);
            switching_freq_setting_i <= 3'(k + 3);
            fs_family_441_i <= k[1];
            wr(`PAMC_OFS_SELECT_B, {4'h0, k[3:1], k[0]});
            check("band", {13'h0, switching_band_o},
                  16'(k[0] ? ((k[3:1] == 3'b111) ? 6 : k[3:1]) : 3'(k + 3)));
            check("table_441", {15'h0, band_table_441_o}, {15'h0, k[1]});
        end
    endtask

    task automatic t_coef();
        wr(`PAMC_OFS_SELECT_A, 8'h00);
        for (int b = 1; b < 7; b++) coef(1'b0, 3'(b), 1'b0, 1'b1);
        for (int e = 1; e < 3; e++) begin
            wr(`PAMC_OFS_SELECT_A, 8'(e));
            for (int b = 1; b < 7; b++) coef(1'b0, 3'(b), 1'b0, b > 4);
            coef(1'b1, 3'd5, 1'b0, 1'b0);
            coef(1'b1, 3'd5, 1'b1, 1'b1);
        end
    endtask

    task automatic t_vol();
        vol_case(8'h00, 8'h18);
        vol_case(8'h60, 8'h00);
        vol_case(8'h61, 8'h4c);
        vol_case(8'hd8, 8'h00);
        vol_case(8'hd9, 8'h01);
        vol_case(8'hec, 8'h00);
        vol_case(8'hec, 8'h01);
        vol_case(8'hed, 8'h00);
        vol_case(8'hff, 8'h00);
        vol_case(8'h00, 8'hfe);
        vol_case(8'h50, 8'hfe);
        vol_case(8'h30, 8'hff);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        errors = 0;
        comparisons = 0;
        reset_n_i = 1'b0;
        {reg_wr_i, reg_addr_i, reg_wdata_i, coef_wr_i, coef_prescale_i} = '0;
        {coef_biquad_i, prescale_user_i, fs_family_441_i} = '0;
        master_offset_code_i = 8'h00;
        channel_gain_code_i = 24'h606060;
        channel_gain_bypass_i = 3'b000;
        switching_freq_setting_i = 3'h0;
        repeat (8) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_regs();
        t_modes();
        t_am();
        t_coef();
        t_vol();
        report_and_stop();
    end
endmodule
